// ---- bus_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// Bus controller side: serial poll on request, keeps the polled byte.
module bus_ctrl_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       poll_go,
  input  wire logic       poll_valid,
  input  wire logic [7:0] poll_data,
  output var  logic       serial_poll,
  output var  logic [7:0] polled_byte
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_poll <= 1'b0;
      polled_byte <= 8'h00;
    end else begin
      serial_poll <= poll_go & ~serial_poll;
      if (poll_valid) polled_byte <= poll_data;
    end
  end
endmodule
`default_nettype wire

// ---- cond_sync.v ----
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Two-stage synchroniser for condition levels arriving from outside.
module cond_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Levels
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ---- status_srq_logic.v ----
`timescale 1ns/10ps
`default_nettype none
`include "status_srq_map.vh"

module status_srq_logic #(
  parameter PRI_COND_W = 5
) (
  // Clock and reset
  input  wire                  clk,
  input  wire                  rst_n,
  // Commands from the parser
  input  wire                  cmd_valid,
  input  wire [`CMD_W-1:0]     cmd_code,
  input  wire [7:0]            cmd_arg,
  input  wire                  serial_poll,
  // Instrument conditions
  input  wire [PRI_COND_W-1:0] pri_cond_in,
  input  wire [7:0]            ext_one_cond_in,
  input  wire [7:0]            ext_two_cond_in,
  // Query answers
  output reg                   resp_valid,
  output reg  [7:0]            resp_data,
  output reg                   resp_last,
  output reg                   busy,
  // Serial poll answer
  output reg                   poll_valid,
  output reg  [7:0]            poll_data,
  // Service request and status view
  output reg                   srq,
  output reg  [7:0]            primary_status,
  output reg  [7:0]            extended_status_one,
  output reg  [7:0]            extended_status_two
);

  // ========================================================================
  // Local types and helpers
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_EXT1 = 2'b01;
  localparam [1:0] ST_EXT2 = 2'b10;

  // Per-bit request enable decode: {hit, on, bit index}.
  function [4:0] req_bit_decode;
    input [`CMD_W-1:0] code;
    begin
      req_bit_decode = 5'h00;
      if (code == `CMD_EXT_ONE_SUMMARY_ON) begin
        req_bit_decode = {1'b1, 1'b1, 3'd`PRI_EXT_ONE_BIT};
      end else if (code == `CMD_EXT_ONE_SUMMARY_OFF) begin
        req_bit_decode = {1'b1, 1'b0, 3'd`PRI_EXT_ONE_BIT};
      end else if (code == `CMD_SWEEP_END_REQ_ON) begin
        req_bit_decode = {1'b1, 1'b1, 3'd`PRI_SWEEP_END_BIT};
      end else if (code == `CMD_SWEEP_END_REQ_OFF) begin
        req_bit_decode = {1'b1, 1'b0, 3'd`PRI_SWEEP_END_BIT};
      end else if (code == `CMD_UNLEVELED_REQ_ON) begin
        req_bit_decode = {1'b1, 1'b1, 3'd`PRI_UNLEVELED_BIT};
      end else if (code == `CMD_UNLEVELED_REQ_OFF) begin
        req_bit_decode = {1'b1, 1'b0, 3'd`PRI_UNLEVELED_BIT};
      end else if (code == `CMD_LOCK_FAULT_REQ_ON) begin
        req_bit_decode = {1'b1, 1'b1, 3'd`PRI_LOCK_BIT};
      end else if (code == `CMD_LOCK_FAULT_REQ_OFF) begin
        req_bit_decode = {1'b1, 1'b0, 3'd`PRI_LOCK_BIT};
      end else if (code == `CMD_RANGE_FAULT_REQ_ON) begin
        req_bit_decode = {1'b1, 1'b1, 3'd`PRI_RANGE_BIT};
      end else if (code == `CMD_RANGE_FAULT_REQ_OFF) begin
        req_bit_decode = {1'b1, 1'b0, 3'd`PRI_RANGE_BIT};
      end else if (code == `CMD_SYNTAX_FAULT_REQ_ON) begin
        req_bit_decode = {1'b1, 1'b1, 3'd`PRI_SYNTAX_BIT};
      end else if (code == `CMD_SYNTAX_FAULT_REQ_OFF) begin
        req_bit_decode = {1'b1, 1'b0, 3'd`PRI_SYNTAX_BIT};
      end else if (code == `CMD_EXT_TWO_SUMMARY_ON) begin
        req_bit_decode = {1'b1, 1'b1, 3'd`PRI_EXT_TWO_BIT};
      end else if (code == `CMD_EXT_TWO_SUMMARY_OFF) begin
        req_bit_decode = {1'b1, 1'b0, 3'd`PRI_EXT_TWO_BIT};
      end
    end
  endfunction

  // Next value of a status byte. Latched bits hold until cleared, and a
  // condition seen in the clearing cycle wins over the clear. Unlatched
  // bits follow their condition while updates are allowed and otherwise
  // hold until cleared.
  function [7:0] status_next;
    input [7:0] cur;
    input [7:0] cond;
    input [7:0] latch;
    input [7:0] used;
    input [7:0] allow;
    input [7:0] clr;
    reg   [7:0] held;
    reg   [7:0] follow;
    begin
      held        = ((cur & ~clr) | cond) & latch;
      follow      = ((cond & allow) | (cur & ~allow & ~clr)) & ~latch;
      status_next = (held | follow) & used;
    end
  endfunction

  // ========================================================================
  // Condition synchronisers
  wire [PRI_COND_W+15:0] cond_sync_w;
  wire [PRI_COND_W-1:0]  pri_cond;
  wire [7:0]             ext_one_cond;
  wire [7:0]             ext_two_cond;

  cond_sync #(
    .WIDTH (PRI_COND_W + 16)
  ) u_cond_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({pri_cond_in, ext_one_cond_in, ext_two_cond_in}),
    .dout  (cond_sync_w)
  );

  assign pri_cond     = cond_sync_w[PRI_COND_W+15:16];
  assign ext_one_cond = cond_sync_w[15:8];
  assign ext_two_cond = cond_sync_w[7:0];

  // ========================================================================
  // State
  reg [7:0] pri_mask_q;
  reg [7:0] ext_one_mask_q;
  reg [7:0] ext_two_mask_q;
  reg       global_en_q;
  reg       locked_allow_q;
  reg       leveled_allow_q;
  reg       unlocked_allow_q;
  reg       param_allow_q;
  reg [1:0] state_q;
  reg [7:0] snap_one_q;
  reg [7:0] snap_two_q;

  // ========================================================================
  // Command decode
  wire       cmd_hit_all;
  wire       cmd_hit_pri;
  wire       take_all;
  wire       take_pri;
  wire       clear_all;
  wire [4:0] req_dec;

  assign cmd_hit_all = cmd_valid && (cmd_code == `CMD_ALL_STATUS_QUERY);
  assign cmd_hit_pri = cmd_valid && (cmd_code == `CMD_PRIMARY_STATUS_QUERY);
  // Queries are taken only while no multi-byte answer is in flight.
  assign take_all    = cmd_hit_all && (state_q == ST_IDLE);
  assign take_pri    = cmd_hit_pri && (state_q == ST_IDLE);
  assign clear_all   = cmd_valid && (cmd_code == `CMD_CLEAR_ALL_STATUS);
  assign req_dec     = req_bit_decode(cmd_code);

  // ========================================================================
  // Status byte next values
  reg [7:0] pri_cond_v;
  reg [7:0] pri_clr_v;
  reg [7:0] ext_one_allow_v;
  reg [7:0] ext_two_allow_v;
  reg [7:0] ext_clr_v;
  reg [7:0] pri_d;
  reg [7:0] ext_one_d;
  reg [7:0] ext_two_d;

  always @* begin
    pri_cond_v = 8'h00;
    pri_cond_v[`PRI_SYNTAX_BIT:`PRI_SWEEP_END_BIT] = pri_cond;

    // Event bits clear on either query or a clear-all; summaries only on the full query or a clear-all.
    pri_clr_v = {8{take_all | clear_all}};
    pri_clr_v[`PRI_SYNTAX_BIT:`PRI_SWEEP_END_BIT] =
      {PRI_COND_W{take_all | take_pri | clear_all}};
    ext_clr_v = {8{take_all | clear_all}};

    ext_one_allow_v = 8'h00;
    ext_one_allow_v[`EXT_ONE_LOCKED_BIT]  = locked_allow_q;
    ext_one_allow_v[`EXT_ONE_LEVELED_BIT] = leveled_allow_q;
    ext_two_allow_v = 8'h00;
    ext_two_allow_v[`EXT_TWO_UNLOCKED_BIT] = unlocked_allow_q;
    ext_two_allow_v[`EXT_TWO_PARAM_BIT]    = param_allow_q;

    ext_one_d = status_next(extended_status_one, ext_one_cond,
                            `EXT_ONE_LATCH_MASK, `EXT_ONE_USED_MASK,
                            ext_one_allow_v, ext_clr_v);
    ext_two_d = status_next(extended_status_two, ext_two_cond,
                            `EXT_TWO_LATCH_MASK, `EXT_TWO_USED_MASK,
                            ext_two_allow_v, ext_clr_v);

    // Summaries look at the extended bytes as they stand after this edge,
    // so a query that clears an extended byte clears its summary as well.
    pri_cond_v[`PRI_EXT_ONE_BIT] = |(ext_one_d & ext_one_mask_q);
    pri_cond_v[`PRI_EXT_TWO_BIT] = |(ext_two_d & ext_two_mask_q);

    pri_d = status_next(primary_status, pri_cond_v, `PRI_LATCH_MASK,
                        `PRI_LATCH_MASK, 8'hFF, pri_clr_v);

    // Request bit: set by the global enable command, cleared only by a
    // serial poll, and the set wins when both arrive together.
    if (cmd_valid && (cmd_code == `CMD_REQUEST_GLOBAL_ON)) begin
      pri_d[`PRI_REQUEST_BIT] = 1'b1;
    end else if (serial_poll) begin
      pri_d[`PRI_REQUEST_BIT] = 1'b0;
    end else begin
      pri_d[`PRI_REQUEST_BIT] = primary_status[`PRI_REQUEST_BIT];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_status      <= `STATUS_RESET;
      extended_status_one <= `STATUS_RESET;
      extended_status_two <= `STATUS_RESET;
    end else begin
      primary_status      <= pri_d;
      extended_status_one <= ext_one_d;
      extended_status_two <= ext_two_d;
    end
  end

  // ========================================================================
  // Masks, global enable and update controls
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pri_mask_q       <= `MASK_RESET;
      ext_one_mask_q   <= `MASK_RESET;
      ext_two_mask_q   <= `MASK_RESET;
      global_en_q      <= `GLOBAL_EN_RESET;
      locked_allow_q   <= `UPDATE_RESET;
      leveled_allow_q  <= `UPDATE_RESET;
      unlocked_allow_q <= `UPDATE_RESET;
      param_allow_q    <= `UPDATE_RESET;
    end else if (cmd_valid) begin
      if (req_dec[4]) begin
        pri_mask_q[req_dec[2:0]] <= req_dec[3];
      end
      if (cmd_code == `CMD_PRIMARY_MASK_WRITE) begin
        pri_mask_q <= cmd_arg;
      end else if (cmd_code == `CMD_EXT_ONE_MASK_WRITE) begin
        ext_one_mask_q <= cmd_arg;
      end else if (cmd_code == `CMD_EXT_TWO_MASK_WRITE) begin
        ext_two_mask_q <= cmd_arg;
      end else if (cmd_code == `CMD_REQUEST_GLOBAL_ON) begin
        global_en_q <= 1'b1;
      end else if (cmd_code == `CMD_REQUEST_GLOBAL_OFF) begin
        global_en_q <= 1'b0;
      end else if (cmd_code == `CMD_LOCKED_UPDATE_BLOCK) begin
        locked_allow_q <= 1'b0;
      end else if (cmd_code == `CMD_LOCKED_UPDATE_ALLOW) begin
        locked_allow_q <= 1'b1;
      end else if (cmd_code == `CMD_LEVELED_UPDATE_BLOCK) begin
        leveled_allow_q <= 1'b0;
      end else if (cmd_code == `CMD_LEVELED_UPDATE_ALLOW) begin
        leveled_allow_q <= 1'b1;
      end else if (cmd_code == `CMD_UNLOCKED_UPDATE_BLOCK) begin
        unlocked_allow_q <= 1'b0;
      end else if (cmd_code == `CMD_UNLOCKED_UPDATE_ALLOW) begin
        unlocked_allow_q <= 1'b1;
      end else if (cmd_code == `CMD_PARAM_CHANGE_BLOCK) begin
        param_allow_q <= 1'b0;
      end else if (cmd_code == `CMD_PARAM_CHANGE_ALLOW) begin
        param_allow_q <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Service request. The request bit itself is left out of the enable
  // product so that it can never be masked or feed back on itself.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srq <= 1'b0;
    end else begin
      srq <= global_en_q &&
             (|(primary_status & pri_mask_q & `PRI_LATCH_MASK));
    end
  end

  // ========================================================================
  // Serial poll answer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_valid <= 1'b0;
      poll_data  <= 8'h00;
    end else begin
      poll_valid <= serial_poll;
      if (serial_poll) begin
        poll_data <= primary_status;
      end
    end
  end

  // ========================================================================
  // Query answer sequencer. The bytes are captured in the query cycle, so
  // the answer shows the state before the query's own clear.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      snap_one_q <= 8'h00;
      snap_two_q <= 8'h00;
      resp_valid <= 1'b0;
      resp_data  <= 8'h00;
      resp_last  <= 1'b0;
      busy       <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      resp_last  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take_all) begin
            resp_valid <= 1'b1;
            resp_data  <= primary_status;
            snap_one_q <= extended_status_one;
            snap_two_q <= extended_status_two;
            state_q    <= ST_EXT1;
            busy       <= 1'b1;
          end else if (take_pri) begin
            resp_valid <= 1'b1;
            resp_data  <= primary_status;
            resp_last  <= 1'b1;
          end
        end
        ST_EXT1: begin
          resp_valid <= 1'b1;
          resp_data  <= snap_one_q;
          state_q    <= ST_EXT2;
        end
        ST_EXT2: begin
          resp_valid <= 1'b1;
          resp_data  <= snap_two_q;
          resp_last  <= 1'b1;
          state_q    <= ST_IDLE;
          busy       <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- status_srq_logic_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "status_srq_map.vh"
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
// ======================================================================
// Self-checking bench.
module status_srq_logic_tb;
  logic clk, rst_n, cmd_valid, serial_poll, poll_go, resp_valid, resp_last, busy;
  logic poll_valid, srq;
  logic [5:0] cmd_code;
  logic [4:0] pri_cond_in;
  logic [7:0] cmd_arg, ext_one_cond_in, ext_two_cond_in, resp_data, poll_data, polled_byte;
  logic [7:0] primary_status, extended_status_one, extended_status_two, a, b, m, m2, p;
  logic [5:0] on_code [0:6];
  logic [5:0] blk_code [0:3];
  logic [15:0] blk_bit [0:3];
  integer errors, tests_run, seed, i, nresp;

  status_srq_logic #(.PRI_COND_W(5)) u_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg), .serial_poll(serial_poll),
    .pri_cond_in(pri_cond_in), .ext_one_cond_in(ext_one_cond_in),
    .ext_two_cond_in(ext_two_cond_in), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_last(resp_last), .busy(busy), .poll_valid(poll_valid), .poll_data(poll_data),
    .srq(srq), .primary_status(primary_status), .extended_status_one(extended_status_one),
    .extended_status_two(extended_status_two));
  bus_ctrl_model u_ctrl (.clk(clk), .rst_n(rst_n), .poll_go(poll_go), .poll_valid(poll_valid),
    .poll_data(poll_data), .serial_poll(serial_poll), .polled_byte(polled_byte));

  function logic [7:0] summ(input logic [7:0] s, input logic [7:0] k);
    summ = {7'h00, |(s & k)};
  endfunction

  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task cmd(input logic [5:0] c, input logic [7:0] v);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_arg   <= v;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task cond(input logic [4:0] x, input logic [7:0] y, input logic [7:0] z);
    @(posedge clk);
    pri_cond_in     <= x;
    ext_one_cond_in <= y;
    ext_two_cond_in <= z;
    tick(4);
  endtask
  task poll;
    @(posedge clk);
    poll_go <= 1'b1;
    @(posedge clk);
    poll_go <= 1'b0;
    tick(2);
  endtask
  task wrap_up;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (resp_valid === 1'b1) nresp++;
  initial begin
    #2000000;
    errors++;
    wrap_up;
  end

  initial begin
    errors = 0; tests_run = 0; nresp = 0; seed = 32'h3dd7;
    rst_n = 1'b0; cmd_valid = 1'b0; cmd_code = 6'h00; cmd_arg = 8'h00; poll_go = 1'b0;
    pri_cond_in = 5'h00; ext_one_cond_in = 8'h00; ext_two_cond_in = 8'h00;
    on_code = '{6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12, 6'h14};
    blk_code = '{6'h16, 6'h18, 6'h1A, 6'h1C};
    blk_bit = '{16'h0008, 16'h0080, 16'h1000, 16'h8000};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    `CHECK({primary_status, extended_status_one, extended_status_two, srq}, 25'h0)
    for (i = 0; i < 8; i++) begin
      cmd(`CMD_CLEAR_ALL_STATUS, 8'h00);
      a = $random(seed);
      m = $random(seed);
      cmd(`CMD_PRIMARY_MASK_WRITE, m);
      cmd(`CMD_REQUEST_GLOBAL_ON, 8'h00);
      cond(a[4:0], 8'h00, 8'h00);
      cond(5'h00, 8'h00, 8'h00);
      p = {2'b01, a[4:0], 1'b0};
      `CHECK(primary_status, p)
      `CHECK(srq, summ(p, m & 8'hBF) == 8'h01)
      cmd(`CMD_PRIMARY_STATUS_QUERY, 8'h00);
      `CHECK(resp_data, p)
      tick(1);
      `CHECK(primary_status, 8'h40)
      poll;
      `CHECK(polled_byte, 8'h40)
      `CHECK(primary_status, 8'h00)
    end
    cmd(`CMD_PRIMARY_MASK_WRITE, 8'h00);
    cmd(`CMD_EXT_ONE_MASK_WRITE, 8'h01);
    cmd(`CMD_EXT_TWO_MASK_WRITE, 8'h04);
    cmd(`CMD_REQUEST_GLOBAL_ON, 8'h00);
    cond(5'h1F, 8'h01, 8'h04);
    for (i = 0; i < 7; i++) begin
      cmd(on_code[i], 8'h00);
      tick(1);
      `CHECK(srq, 1'b1)
      cmd(on_code[i] + 6'h01, 8'h00);
      tick(1);
      `CHECK(srq, 1'b0)
    end
    cmd(`CMD_SWEEP_END_REQ_ON, 8'h00);
    cmd(`CMD_REQUEST_GLOBAL_OFF, 8'h00);
    tick(1);
    `CHECK(srq, 1'b0)
    cond(5'h00, 8'h00, 8'h00);
    poll;
    `CHECK(polled_byte, 8'hFF)
    `CHECK(primary_status, 8'hBF)
    for (i = 0; i < 8; i++) begin
      cmd(`CMD_CLEAR_ALL_STATUS, 8'h00);
      cmd(`CMD_ALL_STATUS_QUERY, 8'h00);
      tick(3);
      a = $random(seed);
      b = $random(seed);
      m = $random(seed);
      m2 = $random(seed);
      if (m[0]) m[2] = 1'b0;
      cmd(`CMD_EXT_ONE_MASK_WRITE, m);
      cmd(`CMD_EXT_TWO_MASK_WRITE, m2);
      cond(5'h00, a, b);
      `CHECK(extended_status_one, a & 8'h8D)
      `CHECK(extended_status_two, b & 8'hDC)
      p = (summ(b & 8'hDC, m2) << 7) | summ(a & 8'h8D, m);
      `CHECK(primary_status & 8'h81, p)
      cond(5'h00, 8'h00, 8'h00);
      `CHECK(extended_status_one, a & 8'h05)
      nresp = 0;
      cmd(`CMD_ALL_STATUS_QUERY, 8'h00);
      `CHECK(resp_data, p)
      cmd(`CMD_PRIMARY_STATUS_QUERY, 8'h00);
      `CHECK(resp_data, b & 8'h4C)
      `CHECK(resp_last, 1'b1)
      tick(3);
      `CHECK(nresp, 3)
      `CHECK(primary_status, 8'h00)
      cmd(`CMD_ALL_STATUS_QUERY, 8'h00);
      tick(3);
      `CHECK({primary_status, extended_status_one, extended_status_two}, 24'h0)
    end
    for (i = 0; i < 4; i++) begin
      cmd(blk_code[i], 8'h00);
      cond(5'h00, 8'h88, 8'h90);
      `CHECK({extended_status_two, extended_status_one}, 16'h9088 & ~blk_bit[i])
      cmd(blk_code[i] + 6'h01, 8'h00);
      tick(3);
      `CHECK({extended_status_two, extended_status_one}, 16'h9088)
      cond(5'h00, 8'h00, 8'h00);
    end
    cond(5'h1F, 8'h05, 8'h4C);
    cond(5'h00, 8'h00, 8'h00);
    cmd(`CMD_CLEAR_ALL_STATUS, 8'h00);
    `CHECK({primary_status & 8'h3E, extended_status_one, extended_status_two}, 24'h0)
    wrap_up;
  end
endmodule
bind status_srq_logic status_srq_props #(.PRI_COND_W(PRI_COND_W)) u_props (.clk(clk),
  .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
  .serial_poll(serial_poll), .pri_cond_in(pri_cond_in), .ext_one_cond_in(ext_one_cond_in),
  .ext_two_cond_in(ext_two_cond_in), .resp_valid(resp_valid), .resp_data(resp_data),
  .resp_last(resp_last), .busy(busy), .poll_valid(poll_valid), .poll_data(poll_data),
  .srq(srq), .primary_status(primary_status), .extended_status_one(extended_status_one),
  .extended_status_two(extended_status_two));
`default_nettype wire

// ---- status_srq_map.vh ----
`ifndef STATUS_SRQ_MAP_VH
`define STATUS_SRQ_MAP_VH

// ==========================================================================
// Command codes presented by the command parser on cmd_code.
`define CMD_W                     6
`define CMD_ALL_STATUS_QUERY      6'h01
`define CMD_PRIMARY_STATUS_QUERY  6'h02
`define CMD_REQUEST_GLOBAL_ON     6'h03
`define CMD_REQUEST_GLOBAL_OFF    6'h04
`define CMD_PRIMARY_MASK_WRITE    6'h05
`define CMD_EXT_ONE_MASK_WRITE    6'h06
`define CMD_EXT_TWO_MASK_WRITE    6'h07
`define CMD_EXT_ONE_SUMMARY_ON    6'h08
`define CMD_EXT_ONE_SUMMARY_OFF   6'h09
`define CMD_SWEEP_END_REQ_ON      6'h0A
`define CMD_SWEEP_END_REQ_OFF     6'h0B
`define CMD_UNLEVELED_REQ_ON      6'h0C
`define CMD_UNLEVELED_REQ_OFF     6'h0D
`define CMD_LOCK_FAULT_REQ_ON     6'h0E
`define CMD_LOCK_FAULT_REQ_OFF    6'h0F
`define CMD_RANGE_FAULT_REQ_ON    6'h10
`define CMD_RANGE_FAULT_REQ_OFF   6'h11
`define CMD_SYNTAX_FAULT_REQ_ON   6'h12
`define CMD_SYNTAX_FAULT_REQ_OFF  6'h13
`define CMD_EXT_TWO_SUMMARY_ON    6'h14
`define CMD_EXT_TWO_SUMMARY_OFF   6'h15
`define CMD_LOCKED_UPDATE_BLOCK   6'h16
`define CMD_LOCKED_UPDATE_ALLOW   6'h17
`define CMD_LEVELED_UPDATE_BLOCK  6'h18
`define CMD_LEVELED_UPDATE_ALLOW  6'h19
`define CMD_UNLOCKED_UPDATE_BLOCK 6'h1A
`define CMD_UNLOCKED_UPDATE_ALLOW 6'h1B
`define CMD_PARAM_CHANGE_BLOCK    6'h1C
`define CMD_PARAM_CHANGE_ALLOW    6'h1D
`define CMD_CLEAR_ALL_STATUS      6'h1E

// ==========================================================================
// Bit positions.
`define PRI_EXT_ONE_BIT   0
`define PRI_SWEEP_END_BIT 1
`define PRI_UNLEVELED_BIT 2
`define PRI_LOCK_BIT      3
`define PRI_RANGE_BIT     4
`define PRI_SYNTAX_BIT    5
`define PRI_REQUEST_BIT   6
`define PRI_EXT_TWO_BIT   7
`define EXT_ONE_LOCKED_BIT   3
`define EXT_ONE_LEVELED_BIT  7
`define EXT_TWO_UNLOCKED_BIT 4
`define EXT_TWO_PARAM_BIT    7

// ==========================================================================
// Field layouts: bits in use and bits that latch.
`define PRI_LATCH_MASK     8'hBF
`define EXT_ONE_USED_MASK  8'h8D
`define EXT_ONE_LATCH_MASK 8'h05
`define EXT_TWO_USED_MASK  8'hDC
`define EXT_TWO_LATCH_MASK 8'h4C

// ==========================================================================
// Reset values.
`define STATUS_RESET    8'h00
`define MASK_RESET      8'h00
`define GLOBAL_EN_RESET 1'b0
`define UPDATE_RESET    1'b1

`endif

// ---- status_srq_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "status_srq_map.vh"
// ======================================================================
// Port-level checks of the status and service-request block.
module status_srq_props #(
  parameter PRI_COND_W = 5
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  cmd_valid,
  input wire logic [5:0]            cmd_code,
  input wire logic [7:0]            cmd_arg,
  input wire logic                  serial_poll,
  input wire logic [PRI_COND_W-1:0] pri_cond_in,
  input wire logic [7:0]            ext_one_cond_in,
  input wire logic [7:0]            ext_two_cond_in,
  input wire logic                  resp_valid,
  input wire logic [7:0]            resp_data,
  input wire logic                  resp_last,
  input wire logic                  busy,
  input wire logic                  poll_valid,
  input wire logic [7:0]            poll_data,
  input wire logic                  srq,
  input wire logic [7:0]            primary_status,
  input wire logic [7:0]            extended_status_one,
  input wire logic [7:0]            extended_status_two
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] quiet_q;
  wire        cmd_q = cmd_valid & (cmd_code == `CMD_PRIMARY_STATUS_QUERY);
  wire        cmd_a = cmd_valid & (cmd_code == `CMD_ALL_STATUS_QUERY);
  wire        cmd_c = cmd_valid & (cmd_code == `CMD_CLEAR_ALL_STATUS);
  wire        cmd_on = cmd_valid & (cmd_code == `CMD_REQUEST_GLOBAL_ON);
  // Counts edges with every condition input low, so a clear is not undone.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) quiet_q <= 3'h0;
    else if (|{pri_cond_in, ext_one_cond_in, ext_two_cond_in}) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end
  srq_cause_a: assert property (srq |-> $past(primary_status & 8'hBF) != 8'h00)
    else $error("srq without an enabled status bit");
  srq_off_a: assert property (cmd_valid && cmd_code == `CMD_REQUEST_GLOBAL_OFF |-> ##2 !srq)
    else $error("srq after global off");
  prim_query_a: assert property (cmd_q && !busy |=> resp_valid && resp_last
    && resp_data == $past(primary_status)) else $error("primary query answer wrong");
  all_query_a: assert property (cmd_a && !busy |=> resp_valid && busy
    && resp_data == $past(primary_status)
    ##1 resp_valid && resp_data == $past(extended_status_one, 2)
    ##1 resp_valid && resp_last && !busy && resp_data == $past(extended_status_two, 3))
    else $error("all-status answer wrong");
  poll_answer_a: assert property (serial_poll |=> poll_valid
    && poll_data == $past(primary_status)) else $error("poll answer wrong");
  poll_clear_a: assert property (serial_poll && !cmd_on |=> !primary_status[6])
    else $error("poll left request bit set");
  global_on_a: assert property (cmd_on |=> primary_status[6])
    else $error("global on did not set request bit");
  req_fall_a: assert property ($fell(primary_status[6]) |-> $past(serial_poll))
    else $error("request bit cleared without poll");
  latched_hold_a: assert property ($fell(primary_status[1])
    |-> $past(cmd_q || cmd_a || cmd_c))
    else $error("latched bit dropped without query");
  clear_all_a: assert property (cmd_c && quiet_q >= 3'h4 |=> extended_status_one == 8'h00
    && extended_status_two == 8'h00 && (primary_status & 8'h3E) == 8'h00)
    else $error("clear-all left bits set");
  all_seen_c: cover property (cmd_a && !busy ##3 resp_last);
  srq_seen_c: cover property ($rose(srq));
  poll_seen_c: cover property (serial_poll && primary_status[6]);
endmodule
`default_nettype wire
